// >>> logic/qcis_defines.svh
// constants for the four-channel current-loop input readout
`ifndef QCIS_DEFINES_SVH
`define QCIS_DEFINES_SVH

// raw count range, 14-bit results only
`define QCIS_RAW_BITS 14
`define QCIS_RAW_MAX 14'h3fff
// count per microamp as 16-bit binary fractions, 0-20 mA and 4-20 mA spans
`define QCIS_GAIN_0_20 17'h0d1b4
`define QCIS_GAIN_4_20 17'h10621
`define QCIS_FRAC_BITS 16
// live zero of the 4-20 mA range and open-loop threshold, in microamps
`define QCIS_LIVE_ZERO_UA 16'h0fa0
`define QCIS_OPEN_LOOP_UA 16'h0ea6

// full update period with every channel enabled
`define QCIS_UPDATE_US 45000
`define QCIS_CLK_MHZ 100
`define QCIS_CHANNELS 4
`define QCIS_SLOT_CYCLES ((`QCIS_UPDATE_US * `QCIS_CLK_MHZ) / `QCIS_CHANNELS)

// 24-bit status area: byte 0 health, byte 1 open loop, byte 2 spare
`define QCIS_STATUS_BITS 24
`define QCIS_ST_SELF_TEST_FAILED 0
`define QCIS_ST_SUPPLY_ABSENT 1
`define QCIS_ST_DATA_NOT_VALID 2
`define QCIS_ST_OPEN_LSB 8
`define QCIS_ST_SPARE_LSB 16

// result word: channel number above the raw count
`define QCIS_WORD_BITS 16
`define QCIS_WORD_CH_LSB 14

// configuration defaults: all channels on, every channel 4-20 mA
`define QCIS_RST_CHAN_COUNT 3'h4
`define QCIS_RST_RANGE 4'hf
// status and host health copy in reset: only data not valid raised
`define QCIS_RST_STATUS 24'h000004
`define QCIS_RST_HEALTH 8'h04

`endif

// >>> logic/qcis_pkg.sv
// types shared by both ends of the current-loop readout link
package qcis_pkg;
  typedef logic [1:0] qcis_chan_t;
  typedef logic [13:0] qcis_raw_t;
  typedef enum logic [1:0] {
    QCIS_S_SETTLE = 2'b01,
    QCIS_S_PUSH = 2'b10
  } qcis_state_e;
endpackage

// >>> logic/qcis_link_if.sv
// link between the readout module and the host processor
`timescale 1ns/1ps
interface qcis_link_if;
  logic cfg_load;
  logic cfg_drop;
  logic [2:0] cfg_chan_count;
  logic [3:0] cfg_range;
  logic word_valid;
  logic word_ready;
  logic [15:0] word_data;
  logic [23:0] status;

  modport device (
    input cfg_load,
    input cfg_drop,
    input cfg_chan_count,
    input cfg_range,
    input word_ready,
    output word_valid,
    output word_data,
    output status
  );

  modport host (
    output cfg_load,
    output cfg_drop,
    output cfg_chan_count,
    output cfg_range,
    output word_ready,
    input word_valid,
    input word_data,
    input status
  );
endinterface

// >>> logic/qcis_device_end.sv
// readout module end: conversion scheduling, raw mapping, status area, result fifo
//
// Operation
// - 0-20 mA gives counts 0..16383, 1.22 uA
// - 4-20 mA span maps to 0..16383, 0.977 uA
// - 24-bit status area, byte aligned
// - byte 0: self test, supply, data invalid
// - byte 1: open-loop flag per channel
// - byte 2 carries nothing
// - open loop only 4-20 mA, below 3.75 mA
// - open-loop flag means that loop is broken
// - flag self test failure while not passed
// - flag missing external 24 V supply
// - data invalid until configured, and after loss
// - host checks data invalid before reading results
// - host picks channel count, default all four
// - no 16-bit option, always 14-bit results
// - range selectable per channel, steers mapping
// - host scales raw span onto engineering span
// - clamp keeps scaled value within limits
// - every channel defaults to 4-20 mA
// - 45 ms full update with four channels
`timescale 1ns/1ps
`include "qcis_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module qcis_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [PW-1:0] next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign in_ready = (count != (PW + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // storage has no reset; a word is only seen once count covers it
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_wr_ptr;
      end
      if (pop) begin
        rd_ptr <= next_rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module qcis_device_end
  import qcis_pkg::*;
#(
  parameter int SLOT_CYCLES = `QCIS_SLOT_CYCLES,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [63:0] LOOP_CURRENT_UA,
  input wire logic SELF_TEST_OK,
  input wire logic FIELD_SUPPLY_OK,
  qcis_link_if.device LINK
);

  // microamps to a 14-bit count; wider results are never produced
  function automatic qcis_raw_t raw_from_ua(input logic [15:0] ua, input logic live_zero);
    logic [15:0] span;
    logic [16:0] gain;
    logic [32:0] prod;
    span = ua;
    gain = `QCIS_GAIN_0_20;
    if (live_zero) begin
      span = (ua < `QCIS_LIVE_ZERO_UA) ? 16'h0000 : ua - `QCIS_LIVE_ZERO_UA;
      gain = `QCIS_GAIN_4_20;
    end
    prod = {17'h00000, span} * {16'h0000, gain};
    if (prod[32:16] > {3'h0, `QCIS_RAW_MAX}) begin
      return `QCIS_RAW_MAX;
    end
    return prod[29:16];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic self_test_meta;
  logic self_test_ok;
  logic supply_meta;
  logic supply_ok;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      self_test_meta <= 1'b0;
      self_test_ok <= 1'b0;
      supply_meta <= 1'b0;
      supply_ok <= 1'b0;
    end else begin
      self_test_meta <= SELF_TEST_OK;
      self_test_ok <= self_test_meta;
      supply_meta <= FIELD_SUPPLY_OK;
      supply_ok <= supply_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration held from the host
  logic configured;
  logic [2:0] chan_count;
  logic [3:0] range_4_20;

  // zero or out-of-range counts fall back to all channels
  wire count_ok = (LINK.cfg_chan_count != 3'h0) && (LINK.cfg_chan_count <= 3'h4);
  wire [2:0] next_chan_count = count_ok ? LINK.cfg_chan_count : `QCIS_RST_CHAN_COUNT;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      configured <= 1'b0;
      chan_count <= `QCIS_RST_CHAN_COUNT;
      range_4_20 <= `QCIS_RST_RANGE;
    end else if (LINK.cfg_drop) begin
      configured <= 1'b0;
      chan_count <= `QCIS_RST_CHAN_COUNT;
      range_4_20 <= `QCIS_RST_RANGE;
    end else if (LINK.cfg_load) begin
      configured <= 1'b1;
      chan_count <= next_chan_count;
      range_4_20 <= LINK.cfg_range;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion schedule: one slot per enabled channel
  qcis_state_e state;
  logic [31:0] slot_cnt;
  qcis_chan_t chan;
  qcis_raw_t raw_hold;
  logic [3:0] open_loop;

  wire slot_done = (slot_cnt == 32'(SLOT_CYCLES - 1));
  wire [15:0] chan_ua = LOOP_CURRENT_UA[{chan, 4'h0} +: 16];
  wire chan_live_zero = range_4_20[chan];
  wire chan_open = chan_live_zero && (chan_ua < `QCIS_OPEN_LOOP_UA);
  wire last_chan = ({1'b0, chan} >= (chan_count - 3'h1));
  wire fifo_in_ready;
  wire push_word = (state == QCIS_S_PUSH);
  wire [15:0] word_in = {chan, raw_hold};

  // fewer channels give a shorter period, since each slot stays fixed
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= QCIS_S_SETTLE;
      slot_cnt <= 32'h0000_0000;
      chan <= 2'h0;
      raw_hold <= 14'h0000;
    end else begin
      case (state)
        QCIS_S_SETTLE: begin
          slot_cnt <= slot_cnt + 32'h0000_0001;
          if (slot_done) begin
            raw_hold <= raw_from_ua(chan_ua, chan_live_zero);
            state <= QCIS_S_PUSH;
          end
        end
        QCIS_S_PUSH: begin
          // a full fifo holds the schedule rather than losing a result
          if (fifo_in_ready) begin
            slot_cnt <= 32'h0000_0000;
            chan <= last_chan ? 2'h0 : chan + 2'h1;
            state <= QCIS_S_SETTLE;
          end
        end
        default: begin
          state <= QCIS_S_SETTLE;
        end
      endcase
    end
  end

  // open-loop flags follow each sample; disabled channels read clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      open_loop <= 4'h0;
    end else begin
      for (int i = 0; i < `QCIS_CHANNELS; i++) begin
        if (i >= int'(chan_count)) begin
          open_loop[i] <= 1'b0;
        end else if ((state == QCIS_S_SETTLE) && slot_done && (int'(chan) == i)) begin
          open_loop[i] <= chan_open;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status area
  logic [23:0] status;
  wire [7:0] health_byte = {5'h00, !configured, !supply_ok, !self_test_ok};
  wire [7:0] open_byte = {4'h0, open_loop};
  wire [7:0] spare_byte = 8'h00;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      status <= `QCIS_RST_STATUS;
    end else begin
      status <= {spare_byte, open_byte, health_byte};
    end
  end

  assign LINK.status = status;

  ////////////////////////////////////////////////////////////////////////////
  // result words to the host
  qcis_word_fifo #(
    .WIDTH(`QCIS_WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .in_valid(push_word),
    .in_ready(fifo_in_ready),
    .in_data(word_in),
    .out_valid(LINK.word_valid),
    .out_ready(LINK.word_ready),
    .out_data(LINK.word_data)
  );

endmodule

// >>> logic/qcis_host_end.sv
// host end: configuration, result pickup, scaling with clamp
`timescale 1ns/1ps
`include "qcis_defines.svh"

module qcis_host_end
  import qcis_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CFG_LOAD,
  input wire logic CFG_DROP,
  input wire logic [2:0] CFG_CHANNELS,
  input wire logic [3:0] CFG_RANGE,
  input wire logic DRAIN_STALL,
  input wire logic [3:0] SCALE_ENABLE,
  input wire logic [3:0] CLAMP_ENABLE,
  input wire logic [63:0] RAW_SCALE_LOW,
  input wire logic [63:0] RAW_SCALE_HIGH,
  input wire logic [63:0] SCALED_LOW_LIMIT,
  input wire logic [63:0] SCALED_HIGH_LIMIT,
  output logic [63:0] RAW_COUNT_WORD,
  output logic [63:0] SCALED_ENGINEERING_VALUE,
  output logic [3:0] RESULT_UPDATED,
  output logic [7:0] MODULE_HEALTH,
  output logic [7:0] CHANNEL_OPEN_LOOP,
  qcis_link_if.host LINK
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration and drain control, all registered
  logic cfg_load;
  logic cfg_drop;
  logic [2:0] cfg_chan_count;
  logic [3:0] cfg_range;
  logic word_ready;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg_load <= 1'b0;
      cfg_drop <= 1'b0;
      cfg_chan_count <= `QCIS_RST_CHAN_COUNT;
      cfg_range <= `QCIS_RST_RANGE;
      word_ready <= 1'b0;
    end else begin
      cfg_load <= CFG_LOAD;
      cfg_drop <= CFG_DROP;
      cfg_chan_count <= CFG_CHANNELS;
      cfg_range <= CFG_RANGE;
      word_ready <= !DRAIN_STALL;
    end
  end

  assign LINK.cfg_load = cfg_load;
  assign LINK.cfg_drop = cfg_drop;
  assign LINK.cfg_chan_count = cfg_chan_count;
  assign LINK.cfg_range = cfg_range;
  assign LINK.word_ready = word_ready;

  ////////////////////////////////////////////////////////////////////////////
  // scaling of the arriving word
  wire take = LINK.word_valid && word_ready;
  wire data_ok = !LINK.status[`QCIS_ST_DATA_NOT_VALID];
  wire [1:0] ch = LINK.word_data[15:14];
  wire [5:0] base = {ch, 4'h0};
  wire [13:0] raw = LINK.word_data[13:0];
  wire signed [16:0] rlo = {1'b0, RAW_SCALE_LOW[base +: 16]};
  wire signed [16:0] rhi = {1'b0, RAW_SCALE_HIGH[base +: 16]};
  wire signed [16:0] slo = {SCALED_LOW_LIMIT[base + 6'd15], SCALED_LOW_LIMIT[base +: 16]};
  wire signed [16:0] shi = {SCALED_HIGH_LIMIT[base + 6'd15], SCALED_HIGH_LIMIT[base +: 16]};
  wire signed [16:0] raw_s = {3'h0, raw};
  wire signed [16:0] den = rhi - rlo;
  wire signed [33:0] num = (raw_s - rlo) * (shi - slo);
  // a zero raw span would divide by zero; the low limit is used instead
  wire signed [33:0] quo = (den == 17'sh0) ? 34'sh0 : num / den;
  wire signed [34:0] interp = {{18{slo[16]}}, slo} + {quo[33], quo};
  wire signed [34:0] lim_lo = {{18{slo[16]}}, slo};
  wire signed [34:0] lim_hi = {{18{shi[16]}}, shi};
  wire clamp_on = CLAMP_ENABLE[ch];
  wire signed [34:0] clamped = (clamp_on && interp < lim_lo) ? lim_lo :
                               (clamp_on && interp > lim_hi) ? lim_hi : interp;
  // no clamp still saturates to the 16-bit result field
  wire signed [34:0] sat = (clamped > 35'sh0_7fff) ? 35'sh0_7fff :
                           (clamped < -35'sh0_8000) ? -35'sh0_8000 : clamped;
  wire [15:0] eng = SCALE_ENABLE[ch] ? sat[15:0] : {2'h0, raw};

  ////////////////////////////////////////////////////////////////////////////
  // result registers; words taken while data is invalid are discarded
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RAW_COUNT_WORD <= 64'h0;
      SCALED_ENGINEERING_VALUE <= 64'h0;
      RESULT_UPDATED <= 4'h0;
      MODULE_HEALTH <= `QCIS_RST_HEALTH;
      CHANNEL_OPEN_LOOP <= 8'h00;
    end else begin
      RESULT_UPDATED <= 4'h0;
      MODULE_HEALTH <= LINK.status[7:0];
      CHANNEL_OPEN_LOOP <= LINK.status[15:8];
      if (take && data_ok) begin
        RAW_COUNT_WORD[base +: 16] <= {2'h0, raw};
        SCALED_ENGINEERING_VALUE[base +: 16] <= eng;
        RESULT_UPDATED[ch] <= 1'b1;
      end
    end
  end

endmodule

// >>> testbench/qcis_link_properties.sv
// link checker for the current-loop readout
`timescale 1ns/1ps
module qcis_link_properties #(
  parameter int SLOT_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic cfg_load,
  input wire logic cfg_drop,
  input wire logic [2:0] cfg_chan_count,
  input wire logic [3:0] cfg_range,
  input wire logic word_valid,
  input wire logic word_ready,
  input wire logic [15:0] word_data,
  input wire logic [23:0] status
);
  // margin covers the push and fifo latency after a slot ends
  localparam int WAIT_MAX = SLOT_CYCLES + 8;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  a_spare_byte_zero: assert property (status[23:16] == 8'h00)
    else $error("spare status byte not zero");
  a_health_upper_zero: assert property (status[7:3] == 5'h00)
    else $error("unused health bits set");
  a_open_upper_zero: assert property (status[15:12] == 4'h0)
    else $error("unused open-loop bits set");
  a_load_clears_invalid: assert property (cfg_load && !cfg_drop |-> ##2 !status[2])
    else $error("data invalid not cleared after load");
  a_drop_sets_invalid: assert property (cfg_drop |-> ##2 status[2])
    else $error("data invalid not set after drop");
  a_invalid_fall_cause: assert property ($fell(status[2]) |-> $past(cfg_load, 2))
    else $error("data invalid cleared without load");
  a_invalid_rise_cause: assert property ($rose(status[2]) |-> $past(cfg_drop, 2))
    else $error("data invalid set without drop");
  a_word_held_stable: assert property (word_valid && !word_ready
    |=> word_valid && $stable(word_data))
    else $error("result word dropped or changed while waiting");
  // disabled channels lose their open-loop flag two edges after the count lands
  a_unused_open_clear: assert property (cfg_load && !cfg_drop && cfg_chan_count == 3'h2
    ##1 !cfg_drop |-> ##2 status[11:10] == 2'h0)
    else $error("open-loop flag left on a disabled channel");
  a_word_rate_bound: assert property (!word_valid |-> ##[1:WAIT_MAX] word_valid)
    else $error("no result word within one slot");
  a_reset_idle_state: assert property ($past(SYS_RST) |-> status == 24'h000004 && !word_valid)
    else $error("state after reset wrong");
endmodule

// >>> testbench/tb_quad_current_input_status.sv
// self-checking bench joining device end and host end
`timescale 1ns/1ps
module tb_quad_current_input_status;
  import qcis_pkg::*;
  localparam int SLOT = 20;
  localparam int LIMIT = 20000;
  typedef struct {
    logic [3:0] rng;
    logic [63:0] ua;
    logic [3:0] sc;
    logic [3:0] cl;
    logic [63:0] raw;
    logic [3:0] open;
  } qcis_row_s;
  qcis_row_s rows [3] = '{
    '{4'h0, {16'h5208, 16'h4e20, 16'h2710, 16'h0000}, 4'hf, 4'h0,
      {16'h3fff, 16'h3fff, 16'h1fff, 16'h0000}, 4'h0},
    '{4'hf, {16'h4e20, 16'h2ee0, 16'h0ea6, 16'h0ea5}, 4'hf, 4'hf,
      {16'h3fff, 16'h1fff, 16'h0000, 16'h0000}, 4'h1},
    '{4'h5, {16'h0bb8, 16'h0bb8, 16'h2ee0, 16'h2710}, 4'h3, 4'h1,
      {16'h0999, 16'h0000, 16'h2665, 16'h17ff}, 4'h4}};
  logic CLK, SYS_RST, st_ok, sup_ok, ld, drop, stall;
  logic [63:0] ua, raw_w, eng_w;
  logic [2:0] chans;
  logic [3:0] rng, sc_en, cl_en, upd;
  logic [7:0] health, openf;
  int n_fail, comparisons, cycles;
  qcis_link_if i_qcis_link_if ();
  qcis_device_end #(.SLOT_CYCLES(SLOT), .FIFO_DEPTH(4)) i_qcis_device_end (.CLK(CLK),
    .SYS_RST(SYS_RST), .LOOP_CURRENT_UA(ua), .SELF_TEST_OK(st_ok),
    .FIELD_SUPPLY_OK(sup_ok), .LINK(i_qcis_link_if.device));
  qcis_host_end i_qcis_host_end (.CLK(CLK), .SYS_RST(SYS_RST), .CFG_LOAD(ld),
    .CFG_DROP(drop), .CFG_CHANNELS(chans), .CFG_RANGE(rng), .DRAIN_STALL(stall),
    .SCALE_ENABLE(sc_en), .CLAMP_ENABLE(cl_en), .RAW_SCALE_LOW({4{16'h03e8}}),
    .RAW_SCALE_HIGH({4{16'h3a98}}), .SCALED_LOW_LIMIT({4{16'hff9c}}),
    .SCALED_HIGH_LIMIT({4{16'h03e8}}), .RAW_COUNT_WORD(raw_w),
    .SCALED_ENGINEERING_VALUE(eng_w), .RESULT_UPDATED(upd), .MODULE_HEALTH(health),
    .CHANNEL_OPEN_LOOP(openf), .LINK(i_qcis_link_if.host));
  qcis_link_properties #(.SLOT_CYCLES(SLOT)) i_qcis_link_properties (.CLK(CLK),
    .SYS_RST(SYS_RST), .cfg_load(i_qcis_link_if.cfg_load),
    .cfg_drop(i_qcis_link_if.cfg_drop), .cfg_chan_count(i_qcis_link_if.cfg_chan_count),
    .cfg_range(i_qcis_link_if.cfg_range), .word_valid(i_qcis_link_if.word_valid),
    .word_ready(i_qcis_link_if.word_ready), .word_data(i_qcis_link_if.word_data),
    .status(i_qcis_link_if.status));
  ////////////////////////////////////////////////////////////////////////////////
  // limits fixed at 1000..15000 raw onto -100..1000
  function automatic logic [15:0] exp_eng(logic [15:0] raw, logic s, logic c);
    int e;
    if (!s) return raw;
    e = -100 + (int'(raw) - 1000) * 1100 / 14000;
    if (c && e < -100) e = -100;
    if (c && e > 1000) e = 1000;
    return e[15:0];
  endfunction
  task automatic check(string name, logic [63:0] exp, logic [63:0] got);
    comparisons++;
    if (exp !== got) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out();
    $display("counts: comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic load_cfg(logic [2:0] n, logic [3:0] r);
    @(posedge CLK);
    chans <= n;
    rng <= r;
    ld <= 1'b1;
    @(posedge CLK);
    ld <= 1'b0;
  endtask
  // two rounds: the first may still carry samples taken before a change
  task automatic wait_round(logic [3:0] mask);
    logic [3:0] seen;
    repeat (2) begin
      seen = 4'h0;
      while ((seen & mask) != mask) begin
        @(posedge CLK);
        #1 seen = seen | upd;
      end
    end
  endtask
  // edges from one update of a channel to its next
  task automatic period(int ch, output int n);
    n = 0;
    while (upd[ch] !== 1'b1) begin
      @(posedge CLK);
      #1;
    end
    @(posedge CLK);
    #1 n = 1;
    while (upd[ch] !== 1'b1) begin
      @(posedge CLK);
      #1 n++;
    end
  endtask
  task automatic watch(int n, output logic [3:0] seen);
    seen = 4'h0;
    repeat (n) begin
      @(posedge CLK);
      #1 seen = seen | upd;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    logic [63:0] e_eng;
    logic [3:0] s;
    int n;
    {SYS_RST, st_ok, sup_ok, ld, drop, stall} = 6'b111000;
    {ua, chans, rng, sc_en, cl_en} = {64'h0, 3'h4, 4'hf, 8'h00};
    {n_fail, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge CLK);
    #1 check("reset status", 24'h000004, i_qcis_link_if.status);
    check("reset health", 8'h04, health);
    @(posedge CLK);
    SYS_RST <= 1'b0;
    watch(100, s);
    check("updates unconfigured", 4'h0, s);
    $display("test unconfigured done");
    foreach (rows[r]) begin
      @(posedge CLK);
      ua <= rows[r].ua;
      sc_en <= rows[r].sc;
      cl_en <= rows[r].cl;
      load_cfg(3'h4, rows[r].rng);
      wait_round(4'hf);
      for (int c = 0; c < 4; c++) begin
        e_eng[c*16 +: 16] = exp_eng(rows[r].raw[c*16 +: 16], rows[r].sc[c],
          rows[r].cl[c]);
      end
      check("raw", rows[r].raw, raw_w);
      check("scaled", e_eng, eng_w);
      check("open flags", {4'h0, rows[r].open}, openf);
      check("wire open byte", {4'h0, rows[r].open}, i_qcis_link_if.status[15:8]);
      $display("test row %0d done", r);
    end
    period(0, n);
    check("full period", 4 * (SLOT + 1), n);
    $display("test period done");
    @(posedge CLK);
    st_ok <= 1'b0;
    repeat (6) @(posedge CLK);
    #1 check("self test", 3'h1, i_qcis_link_if.status[2:0]);
    @(posedge CLK);
    sup_ok <= 1'b0;
    repeat (6) @(posedge CLK);
    #1 check("health", 8'h03, health);
    @(posedge CLK);
    st_ok <= 1'b1;
    sup_ok <= 1'b1;
    repeat (6) @(posedge CLK);
    #1 check("health clear", 8'h00, health);
    $display("test health done");
    @(posedge CLK);
    drop <= 1'b1;
    @(posedge CLK);
    drop <= 1'b0;
    repeat (3) @(posedge CLK);
    #1 check("invalid after drop", 1'b1, i_qcis_link_if.status[2]);
    watch(100, s);
    check("updates after drop", 4'h0, s);
    // loss of configuration puts ch3 back on 4-20 mA, so its 3 mA reads open
    check("default range after drop", 8'h0c, openf);
    $display("test drop done");
    load_cfg(3'h2, 4'hf);
    wait_round(4'h3);
    watch(200, s);
    check("two channels", 4'h3, s);
    period(0, n);
    check("two channel period", 2 * (SLOT + 1), n);
    load_cfg(3'h0, 4'hf);
    watch(200, s);
    check("count zero means four", 4'hf, s);
    $display("test channel count done");
    @(posedge CLK);
    stall <= 1'b1;
    // a word may still be taken at the edge where ready falls
    repeat (2) @(posedge CLK);
    watch(200, s);
    check("updates in stall", 4'h0, s);
    check("fifo holds word", 1'b1, i_qcis_link_if.word_valid);
    @(posedge CLK);
    stall <= 1'b0;
    watch(7, s);
    check("four words drained", 4'hf, s);
    $display("test stall done");
    @(posedge CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CLK);
    #1 check("second reset", {24'h000004, 8'h04}, {i_qcis_link_if.status, health});
    check("reset word valid", 1'b0, i_qcis_link_if.word_valid);
    @(posedge CLK);
    SYS_RST <= 1'b0;
    watch(100, s);
    check("updates after reset", 4'h0, s);
    check("default range after reset", 8'h0c, openf);
    $display("test second reset done");
    close_out();
  end
endmodule
